// >>> inc/sat_pkg.sv
// sat_pkg: constants, field layouts and carrier types of the secondary
// transmit channel 4/5 slot configuration block.
// assumes: a 32-bit apb slave with 12 address bits; 32-bit sample words.
package sat_pkg;

    // register indices; the byte address on apb is four times the index
    localparam logic [7:0]  IDX_CH4   = 8'h21;
    localparam logic [7:0]  IDX_CH5   = 8'h22;
    localparam logic [7:0]  IDX_FMT   = 8'h40;
    localparam logic [7:0]  IDX_STAT  = 8'h41;
    localparam logic [11:0] ADDR_CH4  = {2'h0, IDX_CH4, 2'h0};
    localparam logic [11:0] ADDR_CH5  = {2'h0, IDX_CH5, 2'h0};
    localparam logic [11:0] ADDR_FMT  = {2'h0, IDX_FMT, 2'h0};
    localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

    // values after reset
    localparam logic [7:0] RST_CH4 = 8'h03;
    localparam logic [7:0] RST_CH5 = 8'h04;

    // field positions
    localparam int SLOT_POS  = 0;
    localparam int SLOT_W    = 5;
    localparam int SRC_POS   = 5;
    localparam int RSV_POS   = 7;
    localparam int FMT_W     = 2;
    localparam int ST_VALID  = 5;
    localparam int ST_UNDER  = 6;

    // slot width as a power of two, and sample word width
    localparam int SLOT_LOG2 = 5;
    localparam int SAMPLE_W  = 32;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        SAT_SRC_OFF = 2'b00,
        SAT_SRC_A   = 2'b01,
        SAT_SRC_B   = 2'b10,
        SAT_SRC_RSV = 2'b11
    } sat_src_t;

    typedef enum logic [1:0] {
        SAT_FMT_TDM = 2'b00,
        SAT_FMT_I2S = 2'b01,
        SAT_FMT_LJ  = 2'b10
    } sat_fmt_t;

    typedef enum logic {
        SAT_IDLE = 1'b0,
        SAT_RUN  = 1'b1
    } sat_frm_t;

    typedef struct packed {
        logic               rsvd;
        sat_src_t           src;
        logic [SLOT_W-1:0]  slot;
    } sat_cfg_t;

    // one frame's worth of source words
    typedef struct packed {
        logic [SAMPLE_W-1:0] adc4;
        logic [SAMPLE_W-1:0] temp;
        logic [SAMPLE_W-1:0] loop1;
        logic [SAMPLE_W-1:0] echo1;
    } sat_samples_t;

endpackage

// >>> src/sat_fifo.sv
// sat_fifo: small synchronous fifo with valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sat_fifo #(
    parameter int W     = 128,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // draining side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap naturally only for a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sat_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem_q[rd_q];

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers, fill count and registered full/empty
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_q      <= wr_q + AW'(push);
            rd_q      <= rd_q + AW'(pop);
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != (AW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule // sat_fifo
`default_nettype wire

// >>> src/sat_top.sv
// sat_top: secondary audio port transmit channels 4 and 5, apb registers.
// assumes: bclk and fsync come from the host side, asynchronous to clk,
// bclk well below clk/4; samples arrive one frame set at a time.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module sat_top #(
    parameter int SLOT_LOG2 = sat_pkg::SLOT_LOG2
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic [31:0]          prdata,
    output var  logic                 pready,
    output var  logic                 pslverr,
    // sample stream, one set per frame
    input  wire logic                 smp_valid,
    input  wire sat_pkg::sat_samples_t smp_data,
    output var  logic                 smp_ready,
    // serial link pins
    input  wire logic                 bclk,
    input  wire logic                 fsync,
    output var  logic                 dout,
    output var  logic                 dout_oe_n
);
    localparam int CW = SLOT_LOG2 + 5;

    // a slot never holds more bits than a sample word supplies
    if (SLOT_LOG2 < 4 || SLOT_LOG2 > 5) begin : g_bad_slot
        $error("sat_top slot width must be 16 or 32 bits");
    end

    sat_pkg::sat_cfg_t     cfg4_q, cfg5_q;
    sat_pkg::sat_fmt_t     fmt_q;
    sat_pkg::sat_frm_t     frm_q, nfrm;
    sat_pkg::sat_samples_t cur_q, nw, fifo_data;
    logic                  fifo_valid, pop;
    logic                  under_q;
    logic [4:0]            slot_q, nslot, idx;
    logic [CW-1:0]         cnt_q, ncnt;
    logic                  half_q, nhalf, inwin;
    logic                  act4, act5, bit4, bit5;
    logic                  bclk_s1_q, bclk_s2_q, bclk_s3_q, fs_s1_q, fs_s2_q;
    logic                  rise_ev, fall_ev, fs_r_q, pend_q, start_q, st_half_q;
    logic                  start_now, start_half;
    logic                  wr_en, rd_cyc, hit;
    logic [31:0]           rdata;

    // frame-set buffer; it drains one entry per frame, so it backs up
    sat_fifo #(
        .W     ($bits(sat_pkg::sat_samples_t)),
        .DEPTH (sat_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (smp_valid),
        .in_data   (smp_data),
        .in_ready  (smp_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    // two-flop synchronisers; the third bclk flop only serves edge finding
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
            fs_s1_q   <= 1'b0;
            fs_s2_q   <= 1'b0;
        end else begin
            bclk_s1_q <= bclk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
            fs_s1_q   <= fsync;
            fs_s2_q   <= fs_s1_q;
        end
    end

    assign rise_ev = bclk_s2_q & ~bclk_s3_q;
    assign fall_ev = ~bclk_s2_q & bclk_s3_q;

    // frame start per format; i2s data lags its fsync edge by one bclk
    always_comb begin
        case (fmt_q)
            sat_pkg::SAT_FMT_I2S: begin
                start_now  = pend_q;
                start_half = fs_r_q;
            end
            sat_pkg::SAT_FMT_LJ: begin
                start_now  = fs_s2_q ^ fs_r_q;
                start_half = ~fs_s2_q;
            end
            default: begin
                start_now  = fs_s2_q & ~fs_r_q;
                start_half = 1'b0;
            end
        endcase
    end

    // fsync is sampled on bclk rising edges; start is used at next fall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fs_r_q    <= 1'b0;
            pend_q    <= 1'b0;
            start_q   <= 1'b0;
            st_half_q <= 1'b0;
        end else if (rise_ev) begin
            fs_r_q  <= fs_s2_q;
            pend_q  <= fs_s2_q ^ fs_r_q;
            if (start_now) begin
                start_q   <= 1'b1;
                st_half_q <= start_half;
            end
        end else if (fall_ev) begin
            start_q <= 1'b0;
        end
    end

    // next bit position: restart at a half or frame start, else count on
    always_comb begin
        ncnt  = cnt_q;
        nhalf = half_q;
        nfrm  = frm_q;
        case (frm_q)
            sat_pkg::SAT_RUN: begin
                if (&cnt_q) begin
                    nfrm = sat_pkg::SAT_IDLE;
                end else begin
                    ncnt = cnt_q + CW'(1);
                end
            end
            default: ;
        endcase
        if (start_q) begin
            ncnt  = '0;
            nhalf = st_half_q;
            nfrm  = sat_pkg::SAT_RUN;
        end
    end

    // a new sample set is taken at the left-half or tdm frame start
    assign pop = fall_ev & start_q & ~st_half_q & fifo_valid;
    assign nw  = (start_q & ~st_half_q) ? (fifo_valid ? fifo_data : '0) : cur_q;

    // slot mapping
    // tdm uses 32 slots; i2s/lj use 16 per half, the half gives bit 4
    always_comb begin
        if (fmt_q == sat_pkg::SAT_FMT_I2S || fmt_q == sat_pkg::SAT_FMT_LJ) begin
            nslot = {nhalf, ncnt[CW-2:SLOT_LOG2]};
            inwin = ~ncnt[CW-1];
        end else begin
            nslot = ncnt[CW-1:SLOT_LOG2];
            inwin = 1'b1;
        end
    end

    // msb first; a 16-bit slot carries the upper half of the word
    assign idx = 5'(sat_pkg::SAMPLE_W - 1) - 5'(ncnt[SLOT_LOG2-1:0]);

    // source enable
    // selector zero, and the reserved value, leave the channel silent
    assign act4 = (nfrm == sat_pkg::SAT_RUN) & inwin & (nslot == cfg4_q.slot)
                & (cfg4_q.src == sat_pkg::SAT_SRC_A || cfg4_q.src == sat_pkg::SAT_SRC_B);
    assign act5 = (nfrm == sat_pkg::SAT_RUN) & inwin & (nslot == cfg5_q.slot)
                & (cfg5_q.src == sat_pkg::SAT_SRC_A || cfg5_q.src == sat_pkg::SAT_SRC_B);

    assign bit4 = (cfg4_q.src == sat_pkg::SAT_SRC_A) ? nw.adc4[idx] : nw.temp[idx];
    assign bit5 = (cfg5_q.src == sat_pkg::SAT_SRC_A) ? nw.loop1[idx] : nw.echo1[idx];

    // pin drive
    // data changes on bclk fall; channel 4 wins if both share a slot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dout      <= 1'b0;
            dout_oe_n <= 1'b1;
            cnt_q     <= '0;
            half_q    <= 1'b0;
            frm_q     <= sat_pkg::SAT_IDLE;
            slot_q    <= '0;
            cur_q     <= '0;
        end else if (fall_ev) begin
            dout      <= act4 ? bit4 : (act5 & bit5);
            dout_oe_n <= ~(act4 | act5);
            cnt_q     <= ncnt;
            half_q    <= nhalf;
            frm_q     <= nfrm;
            slot_q    <= nslot;
            cur_q     <= nw;
        end
    end

    // apb: one wait state, so every access takes three cycles including setup
    assign rd_cyc = psel & penable & ~pready;
    assign wr_en  = psel & penable & pready & pwrite;

    // read decode; unmapped addresses answer with an error and zero
    always_comb begin
        rdata = '0;
        hit   = 1'b1;
        if (paddr == sat_pkg::ADDR_CH4) begin
            rdata[7:0] = cfg4_q;
        end else if (paddr == sat_pkg::ADDR_CH5) begin
            rdata[7:0] = cfg5_q;
        end else if (paddr == sat_pkg::ADDR_FMT) begin
            rdata[sat_pkg::FMT_W-1:0] = fmt_q;
        end else if (paddr == sat_pkg::ADDR_STAT) begin
            rdata[sat_pkg::SLOT_W-1:0] = slot_q;
            rdata[sat_pkg::ST_VALID]   = fifo_valid;
            rdata[sat_pkg::ST_UNDER]   = under_q;
        end else begin
            hit = 1'b0;
        end
    end

    // bus answer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= rd_cyc;
            pslverr <= rd_cyc & ~hit;
            if (rd_cyc) begin
                prdata <= pwrite ? '0 : rdata;
            end
        end
    end

    // reserved bit is read-only zero, written data is dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg4_q <= sat_pkg::RST_CH4;
            cfg5_q <= sat_pkg::RST_CH5;
            fmt_q  <= sat_pkg::SAT_FMT_TDM;
        end else if (wr_en) begin
            if (paddr == sat_pkg::ADDR_CH4) begin
                cfg4_q <= {1'b0, pwdata[sat_pkg::RSV_POS-1:0]};
            end else if (paddr == sat_pkg::ADDR_CH5) begin
                cfg5_q <= {1'b0, pwdata[sat_pkg::RSV_POS-1:0]};
            end else if (paddr == sat_pkg::ADDR_FMT) begin
                fmt_q <= sat_pkg::sat_fmt_t'(pwdata[sat_pkg::FMT_W-1:0]);
            end
        end
    end

    // underrun flag: a frame started with no sample set; set beats clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            under_q <= 1'b0;
        end else if (fall_ev & start_q & ~st_half_q & ~fifo_valid) begin
            under_q <= 1'b1;
        end else if (wr_en && paddr == sat_pkg::ADDR_STAT && pwdata[sat_pkg::ST_UNDER]) begin
            under_q <= 1'b0;
        end
    end

    // checks
    logic seen_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_tick4;
        fall_ev && act4;
    endsequence
    sequence s_tick5;
        fall_ev && act5 && !act4;
    endsequence

    tri4_off_a: assert property (fall_ev && cfg4_q.src == sat_pkg::SAT_SRC_OFF && !act5
        |=> dout_oe_n) else $error("channel 4 off but pin driven");
    adc4_send_a: assert property (s_tick4 ##0 cfg4_q.src == sat_pkg::SAT_SRC_A
        |=> !dout_oe_n && dout == $past(nw.adc4[idx])) else $error("adc 4 bit wrong");
    temp4_send_a: assert property (s_tick4 ##0 cfg4_q.src == sat_pkg::SAT_SRC_B
        |=> !dout_oe_n && dout == $past(nw.temp[idx])) else $error("temp bit wrong");
    tri5_off_a: assert property (fall_ev && cfg5_q.src == sat_pkg::SAT_SRC_OFF && !act4
        |=> dout_oe_n) else $error("channel 5 off but pin driven");
    loop5_send_a: assert property (s_tick5 ##0 cfg5_q.src == sat_pkg::SAT_SRC_A
        |=> !dout_oe_n && dout == $past(nw.loop1[idx])) else $error("loopback bit wrong");
    echo5_send_a: assert property (s_tick5 ##0 cfg5_q.src == sat_pkg::SAT_SRC_B
        |=> !dout_oe_n && dout == $past(nw.echo1[idx])) else $error("echo bit wrong");
    slot_left_a: assert property (s_tick4 ##0 !cfg4_q.slot[4]
        ##0 (fmt_q == sat_pkg::SAT_FMT_I2S || fmt_q == sat_pkg::SAT_FMT_LJ)
        |=> !half_q && slot_q == $past(cfg4_q.slot)) else $error("left slot");
    slot_right_a: assert property (s_tick4 ##0 cfg4_q.slot[4]
        ##0 (fmt_q == sat_pkg::SAT_FMT_I2S || fmt_q == sat_pkg::SAT_FMT_LJ)
        |=> half_q && slot_q[3:0] == $past(cfg4_q.slot[3:0]))
        else $error("right slot wrong");
    rst_ch4_a: assert property (!seen_q |-> cfg4_q == sat_pkg::RST_CH4)
        else $error("channel 4 reset value wrong");
    rst_ch5_a: assert property (!seen_q |-> cfg5_q == sat_pkg::RST_CH5)
        else $error("channel 5 reset value wrong");
    rsv_zero_a: assert property (wr_en && paddr == sat_pkg::ADDR_CH4
        |=> !cfg4_q.rsvd ##1 !cfg4_q.rsvd) else $error("reserved bit set");
    frame_idle_a: assert property (fall_ev && frm_q == sat_pkg::SAT_IDLE && !start_q
        |=> dout_oe_n) else $error("pin driven outside a frame");
    apb_wait_a: assert property (rd_cyc |=> pready ##1 !pready) else $error("apb answer timing");

endmodule // sat_top
`default_nettype wire

// >>> bench/sat_host_model.sv
// sat_host_model: far-side host that clocks whole frames into the link
// and records what the block puts on the data line.
// assumes: one frame at a time, started by the bench through run_frame.
`timescale 1ns/10ps
`default_nettype none
module sat_host_model (
    // link clocks made by the host
    output var  logic bclk,
    output var  logic fsync,
    // serial data from the block
    input  wire logic dout,
    input  wire logic dout_oe_n
);
    logic cap_oe_n [1024];
    logic cap_ln   [1024];
    logic line_q;

    // idle link: bit clock stands still between frames
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        line_q = 1'b0;
    end

    // one preamble period, then bit periods of 400 ns; a bit is taken a
    // full period after the fall that launched it, so the block's lag of
    // 2-3 clk never races the capture
    task automatic run_frame(input sat_pkg::sat_fmt_t fmt);
        #13;
        for (int i = -1; i <= 1025; i++) begin
            if (i >= 2) begin
                // no pull on the line: a released line shows a changing level
                line_q = dout_oe_n ? ~line_q : dout;
                cap_oe_n[i-2] = dout_oe_n;
                cap_ln[i-2] = line_q;
            end
            bclk = 1'b0;
            if (fmt == sat_pkg::SAT_FMT_TDM) begin
                fsync = (i == 0);
            end else if (fmt == sat_pkg::SAT_FMT_LJ) begin
                fsync = (i >= 0 && i < 512);
            end else begin
                fsync = !(i >= 0 && i < 512);
            end
            #200;
            bclk = 1'b1;
            #200;
        end
        bclk = 1'b0;
    endtask
endmodule // sat_host_model
`default_nettype wire

// >>> bench/sat_top_tb.sv
// sat_top_tb: self-checking bench for transmit channels 4 and 5.
// assumes: sat_host_model makes the link clocks and records the line.
`timescale 1ns/10ps
`default_nettype none
module sat_top_tb;
    logic                  clk;
    logic                  rstn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  smp_valid;
    sat_pkg::sat_samples_t smp_data;
    logic                  smp_ready;
    logic                  bclk;
    logic                  fsync;
    logic                  dout;
    logic                  dout_oe_n;
    int                    errors;
    int                    num_checks;
    sat_pkg::sat_samples_t q[$];
    sat_pkg::sat_samples_t prev_s;
    logic [31:0]           d;
    logic                  e;
    logic [4:0]            r4;
    logic [4:0]            r5;
    int                    n;

    sat_top uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp_valid(smp_valid), .smp_data(smp_data),
        .smp_ready(smp_ready), .bclk(bclk), .fsync(fsync), .dout(dout),
        .dout_oe_n(dout_oe_n)
    );

    sat_host_model host (.bclk(bclk), .fsync(fsync), .dout(dout), .dout_oe_n(dout_oe_n));

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        chk_reg(32'(k < 20), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, wd, x, y);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] x;
        logic y;
        apb(1'b0, a, 32'h0, x, y);
        chk_reg(x, exp);
        chk_reg({31'h0, y}, {31'h0, eerr});
    endtask

    // one random sample set, held until the fifo takes it
    task automatic push();
        sat_pkg::sat_samples_t s;
        int k;
        s = {$urandom, $urandom, $urandom, $urandom};
        k = 0;
        smp_valid <= 1'b1;
        smp_data <= s;
        @(posedge clk);
        while (smp_ready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        smp_valid <= 1'b0;
        q.push_back(s);
        @(posedge clk);
    endtask

    // expected {driving, bit} at position p of the frame; channel 4 wins a shared slot
    function automatic logic [1:0] exp_bit(input int p, input logic [7:0] c4,
                                           input logic [7:0] c5,
                                           input sat_pkg::sat_samples_t s);
        logic [4:0] sl;
        int b;
        if (p < 0) return 2'b00;
        sl = p[9:5];
        b = 31 - int'(p[4:0]);
        if (c4[4:0] == sl && c4[6:5] == 2'd1) return {1'b1, s.adc4[b]};
        if (c4[4:0] == sl && c4[6:5] == 2'd2) return {1'b1, s.temp[b]};
        if (c5[4:0] == sl && c5[6:5] == 2'd1) return {1'b1, s.loop1[b]};
        if (c5[4:0] == sl && c5[6:5] == 2'd2) return {1'b1, s.echo1[b]};
        return 2'b00;
    endfunction

    // set up both channels, run one frame, compare every bit period
    task automatic frame(input sat_pkg::sat_fmt_t f, input logic [7:0] c4,
                         input logic [7:0] c5);
        sat_pkg::sat_samples_t s;
        int off;
        logic pre;
        wr(sat_pkg::ADDR_FMT, {30'h0, f});
        wr(sat_pkg::ADDR_CH4, {24'h0, c4});
        wr(sat_pkg::ADDR_CH5, {24'h0, c5});
        s = (q.size() > 0) ? q.pop_front() : '0;
        off = (f == sat_pkg::SAT_FMT_I2S) ? 1 : 0;
        // i2s from a low idle fsync: the preamble rise opens a right half whose
        // first bit, from the older sample set, lands in the first capture
        pre = (f == sat_pkg::SAT_FMT_I2S) && (fsync === 1'b0);
        host.run_frame(f);
        @(posedge clk);
        for (int p = 0; p < 1024; p++) begin
            chk_bit({~host.cap_oe_n[p], host.cap_ln[p] & ~host.cap_oe_n[p]},
                    (pre && p == 0) ? exp_bit(512, c4, c5, prev_s)
                                    : exp_bit(p - off, c4, c5, s));
        end
        prev_s = s;
        $display("test frame format %0d done", f);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang ends the run as a mismatch
    initial begin
        #3_500_000;
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        smp_valid = 1'b0;
        smp_data = '0;
        prev_s = '0;
        void'($urandom(59923));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(sat_pkg::ADDR_CH4, 32'h03, 1'b0);
        rd_chk(sat_pkg::ADDR_CH5, 32'h04, 1'b0);
        // software keeps reserved bit 7 and selector three out of its writes
        wr(sat_pkg::ADDR_CH4, 32'h5f);
        rd_chk(sat_pkg::ADDR_CH4, 32'h5f, 1'b0);
        rd_chk(12'h0fc, 32'h0, 1'b1);
        $display("test registers done");
        // fifo fills while the link stands still
        n = 0;
        while (smp_ready === 1'b1 && n < 8) begin
            push();
            n++;
        end
        chk_reg(32'(n), 32'h4);
        $display("test fifo fill done");
        r4 = 5'($urandom);
        r5 = r4 + 5'($urandom_range(1, 30));
        frame(sat_pkg::SAT_FMT_TDM, 8'h20, 8'h3f);
        frame(sat_pkg::SAT_FMT_LJ, 8'h4f, 8'h50);
        frame(sat_pkg::SAT_FMT_LJ, {3'h1, 1'b1, r4[3:0]}, {3'h0, r5});
        frame(sat_pkg::SAT_FMT_I2S, {3'h0, r4}, {3'h1, r5});
        frame(sat_pkg::SAT_FMT_TDM, {3'h1, r5}, {3'h0, r5});
        frame(sat_pkg::SAT_FMT_TDM, 8'h43, 8'h44);
        // empty fifo sent zeros and left the sticky underrun flag
        apb(1'b0, sat_pkg::ADDR_STAT, 32'h0, d, e);
        chk_reg({31'h0, d[6]}, 32'h1);
        chk_reg({31'h0, d[5]}, 32'h0);
        wr(sat_pkg::ADDR_STAT, 32'h40);
        apb(1'b0, sat_pkg::ADDR_STAT, 32'h0, d, e);
        chk_reg({31'h0, d[6]}, 32'h0);
        $display("test underrun done");
        close_out();
    end
endmodule // sat_top_tb
`default_nettype wire
